// ### atsp_pkg.sv
// Purpose: shared constants for the aux timer and serial port block
// Assumes: APB word addressing, register index times four is the byte address
// Notes: all reset values are zero
package atsp_pkg;

   // --------------------------------------------------------------
   // register indices and byte addresses
   // --------------------------------------------------------------
   localparam int ADDR_W = 10;
   localparam logic [7:0] IDX_POWER_CONTROL = 8'h87;
   localparam logic [7:0] IDX_SERIAL_CONTROL = 8'h98;
   localparam logic [7:0] IDX_SERIAL_BUFFER = 8'h99;
   localparam logic [7:0] IDX_IE = 8'hA8;
   localparam logic [7:0] IDX_IP = 8'hB8;
   localparam logic [7:0] IDX_AUX_TIMER_CONTROL = 8'hC8;
   localparam logic [7:0] IDX_AUX_RELOAD_LOW = 8'hCA;
   localparam logic [7:0] IDX_AUX_RELOAD_HIGH = 8'hCB;
   localparam logic [7:0] IDX_CNTL = 8'hCC;
   localparam logic [7:0] IDX_CNTH = 8'hCD;
   localparam logic [ADDR_W-1:0] A_POWER_CONTROL = {IDX_POWER_CONTROL, 2'b00};
   localparam logic [ADDR_W-1:0] A_SERIAL_CONTROL = {IDX_SERIAL_CONTROL, 2'b00};
   localparam logic [ADDR_W-1:0] A_SERIAL_BUFFER = {IDX_SERIAL_BUFFER, 2'b00};
   localparam logic [ADDR_W-1:0] A_IE = {IDX_IE, 2'b00};
   localparam logic [ADDR_W-1:0] A_IP = {IDX_IP, 2'b00};
   localparam logic [ADDR_W-1:0] A_AUX_TIMER_CONTROL = {IDX_AUX_TIMER_CONTROL, 2'b00};
   localparam logic [ADDR_W-1:0] A_AUX_RELOAD_LOW = {IDX_AUX_RELOAD_LOW, 2'b00};
   localparam logic [ADDR_W-1:0] A_AUX_RELOAD_HIGH = {IDX_AUX_RELOAD_HIGH, 2'b00};
   localparam logic [ADDR_W-1:0] A_CNTL = {IDX_CNTL, 2'b00};
   localparam logic [ADDR_W-1:0] A_CNTH = {IDX_CNTH, 2'b00};

   // --------------------------------------------------------------
   // reset values and write masks
   // --------------------------------------------------------------
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [15:0] RST_CNT = 16'h0000;
   localparam logic [7:0] POWER_CONTROL_WMASK = 8'hD0;

   // --------------------------------------------------------------
   // field positions
   // --------------------------------------------------------------
   localparam int B_TF2 = 7;
   localparam int B_AUX_TRIGGER_FLAG = 6;
   localparam int B_RCLK = 5;
   localparam int B_TX_BAUD_SELECT = 4;
   localparam int B_AUX_TRIGGER_ENABLE = 3;
   localparam int B_TR2 = 2;
   localparam int B_CT2 = 1;
   localparam int B_CAPTURE_MODE_SELECT = 0;
   localparam int B_SM0 = 7;
   localparam int B_SM1 = 6;
   localparam int B_SM2 = 5;
   localparam int B_REN = 4;
   localparam int B_TB8 = 3;
   localparam int B_RB8 = 2;
   localparam int B_TI = 1;
   localparam int B_RI = 0;
   localparam int B_EA = 7;
   localparam int B_ET2 = 5;
   localparam int B_ES = 4;
   localparam int B_PT2 = 5;
   localparam int B_MODE2_RATE_DOUBLE = 7;

   // --------------------------------------------------------------
   // interrupt identity and serial timing counts
   // --------------------------------------------------------------
   localparam logic [7:0] AUX_IRQ_VECTOR = 8'h2B;
   localparam logic [2:0] AUX_IRQ_NAT_PRIO = 3'h6;
   localparam logic [3:0] OVS_MID = 4'h7;
   localparam logic [3:0] OVS_LAST = 4'hF;
   localparam logic [3:0] M0_LAST = 4'hB;
   localparam logic [3:0] M0_HALF = 4'h6;
   localparam logic [3:0] M0_BITS = 4'h8;
   localparam logic [3:0] M1_BITS = 4'hA;
   localparam logic [3:0] M9_BITS = 4'hB;
   localparam logic [3:0] M1_LAST = 4'h9;
   localparam logic [3:0] M9_LAST = 4'hA;

   // serial modes in uart_mode_hi/uart_mode_lo order
   typedef enum logic [1:0] {ATSP_SHIFT, ATSP_UART8, ATSP_UART9F, ATSP_UART9V} atsp_mode_t;

endpackage

// ### atsp_fall_det.sv
// Purpose: synchronise a pin and flag its falling edges
// Assumes: one clock, synchronous reset, clock enable freezes state
// Notes: edge pulse is one enabled cycle long
module atsp_fall_det (
   // clock and control
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // pin and event
   input wire logic pin,
   output logic fall
);
   // three-stage sample chain
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } atsp_fd_t;

   atsp_fd_t f_q;
   atsp_fd_t f_d;

   // only s2 reads s1; edge compares s2 and s3
   always_comb begin
      f_d = f_q;
      f_d.s1 = pin;
      f_d.s2 = f_q.s1;
      f_d.s3 = f_q.s2;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         f_q <= '0;
      end else if (clk_en) begin
         f_q <= f_d;
      end
   end

   // high then low in successive samples
   assign fall = f_q.s3 & ~f_q.s2;
endmodule

// ### atsp_top.sv
// Purpose: 16-bit aux timer with capture/reload and a full duplex serial port
// Assumes: APB slave, zero wait access after setup, pins synchronous
// Notes: timer1 overflow arrives as a one-cycle input pulse
//
// Contract
// [RULE_01] auto-reload: overflow sets flag, reloads count
// [RULE_02] capture: overflow flag, trigger copies count
// [RULE_03] rx baud from aux or timer1 overflow
// [RULE_04] tx baud from aux or timer1 overflow
// [RULE_05] aux_run gates all counting
// [RULE_06] count clock internal or count pin falls
// [RULE_07] trigger edges ignored unless enabled
// [RULE_08] reload on overflow or trigger; baud: overflow only
// [RULE_09] trigger flag set by edge, software clears
// [RULE_10] no overflow flag in baud mode; sticky
// [RULE_11] flags request vector 0x2B, gated, priority bit
// [RULE_12] software writes set or clear flags
// [RULE_13] full duplex, double buffered receive
// [RULE_14] buffer reads receive, writes start transmit
// [RULE_15] filter drops ninth-bit-zero frames
// [RULE_16] mode pair selects four serial modes
// [RULE_17] mode 2 rate clock/64 or clock/32
// [RULE_18] modes 1,3 follow selected timer overflow
// [RULE_19] receive only while rx_enable set
// [RULE_20] ninth bit sent and stored; mode 1 stop
// [RULE_21] software writes zeros to power bits 2:0
// [RULE_22] mode 0 shift clock clock/12, LSB first
// [RULE_23] mode 1 frame is ten bits
// [RULE_24] modes 2,3 frame is eleven bits
// [RULE_25] done flags set by hardware, software clears
// [RULE_26] pins synchronised, falls from successive samples
// [RULE_27] synchronous reset clears all registers
module atsp_top
   import atsp_pkg::*;
(
   // clock, reset, enable
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // timer pins and timer1 overflow pulse
   input wire logic aux_count_pin,
   input wire logic aux_trigger_pin,
   input wire logic timer1_ovf,
   // serial pins
   input wire logic rxd_in,
   output logic rxd_out,
   output logic rxd_oe,
   output logic txd_out,
   // interrupt requests
   output logic aux_irq_req,
   output logic aux_irq_high,
   output logic [7:0] aux_irq_vector,
   output logic uart_irq_req
);

   // --------------------------------------------------------------
   // state
   // --------------------------------------------------------------
   typedef struct packed {
      logic [15:0] cnt;    // aux count high:low
      logic [15:0] rld;    // reload/capture high:low
      logic [7:0] aux_timer_control;   // aux timer control
      logic [7:0] power_control;    // power control
      logic [7:0] serial_control;    // serial control
      logic [7:0] ie;      // interrupt enable
      logic [7:0] ip;      // interrupt priority
      logic [7:0] rbuf;    // receive buffer
      logic [7:0] rdat;    // read data latch
      logic rv;            // setup seen, answer due
      logic t_busy;        // shift engine running
      logic t_rx;          // mode 0 receive in engine
      logic [10:0] t_sh;   // transmit frame shifter
      logic [3:0] t_bits;  // bits left to shift
      logic [3:0] t_sub;   // oversample phase
      logic [3:0] t_pre;   // mode 0 divide by 12
      logic r_on;          // async receive active
      logic [8:0] r_sh;    // receive shifter
      logic [3:0] r_bits;  // received bit index
      logic [3:0] r_sub;   // receive oversample phase
      logic [1:0] div;     // mode 2 prescaler
   } atsp_state_t;

   atsp_state_t s_q;
   atsp_state_t s_d;

   // decoded controls
   atsp_mode_t mode;
   logic cnt_fall;
   logic trig_fall;
   logic run;
   logic cap;
   logic baud;
   logic tick_t;
   logic ovf;
   logic trig;
   logic m2tick;
   logic ttick;
   logic rtick;
   logic wr;
   logic [7:0] wb;
   logic w_cnt;
   logic w_rld;
   logic w_aux_timer_control;
   logic w_serial_control;
   logic w_serial_buffer;
   logic rd_hit;
   logic [7:0] rd_data;
   logic [3:0] rlast;
   logic nin;
   logic [7:0] rfin;

   // --------------------------------------------------------------
   // pin synchronisers
   // --------------------------------------------------------------
   atsp_fall_det u_cnt_fd (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .pin(aux_count_pin),
      .fall(cnt_fall)
   );

   atsp_fall_det u_trg_fd (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .pin(aux_trigger_pin),
      .fall(trig_fall)
   );

   // --------------------------------------------------------------
   // functions
   // --------------------------------------------------------------
   // register read mux, bit 8 is the address hit
   function automatic logic [8:0] rd_word(input logic [ADDR_W-1:0] a,
                                          input atsp_state_t st);
      case (a)
         A_POWER_CONTROL: rd_word = {1'b1, st.power_control};
         A_SERIAL_CONTROL: rd_word = {1'b1, st.serial_control};
         A_SERIAL_BUFFER: rd_word = {1'b1, st.rbuf}; // RULE_14
         A_IE: rd_word = {1'b1, st.ie};
         A_IP: rd_word = {1'b1, st.ip};
         A_AUX_TIMER_CONTROL: rd_word = {1'b1, st.aux_timer_control};
         A_AUX_RELOAD_LOW: rd_word = {1'b1, st.rld[7:0]};
         A_AUX_RELOAD_HIGH: rd_word = {1'b1, st.rld[15:8]};
         A_CNTL: rd_word = {1'b1, st.cnt[7:0]};
         A_CNTH: rd_word = {1'b1, st.cnt[15:8]};
         default: rd_word = 9'h000;
      endcase
   endfunction

   // 16x oversample tick for one direction
   function automatic logic baud16(input atsp_mode_t md, input logic sel,
                                   input logic m2, input logic aux, input logic t1);
      if (md == ATSP_UART9F) begin
         baud16 = m2;
      end else begin
         baud16 = sel ? aux : t1;
      end
   endfunction

   // --------------------------------------------------------------
   // decode
   // --------------------------------------------------------------
   assign mode = atsp_mode_t'({s_q.serial_control[B_SM0], s_q.serial_control[B_SM1]}); // RULE_16
   assign run = s_q.aux_timer_control[B_TR2];
   assign cap = s_q.aux_timer_control[B_CAPTURE_MODE_SELECT];
   assign baud = s_q.aux_timer_control[B_RCLK] | s_q.aux_timer_control[B_TX_BAUD_SELECT];
   assign tick_t = run & (s_q.aux_timer_control[B_CT2] ? cnt_fall : 1'b1); // RULE_05 RULE_06
   assign ovf = tick_t & (s_q.cnt == 16'hFFFF);
   assign trig = s_q.aux_timer_control[B_AUX_TRIGGER_ENABLE] & trig_fall; // RULE_07 RULE_26
   assign m2tick = s_q.power_control[B_MODE2_RATE_DOUBLE] ? s_q.div[0] : (&s_q.div); // RULE_17
   assign ttick = baud16(mode, s_q.aux_timer_control[B_TX_BAUD_SELECT], m2tick, ovf, timer1_ovf); // RULE_04 RULE_18
   assign rtick = baud16(mode, s_q.aux_timer_control[B_RCLK], m2tick, ovf, timer1_ovf); // RULE_03
   assign wr = psel & penable & pwrite & s_q.rv;
   assign wb = pwdata[7:0];
   assign w_cnt = wr & ((paddr == A_CNTL) | (paddr == A_CNTH));
   assign w_rld = wr & ((paddr == A_AUX_RELOAD_LOW) | (paddr == A_AUX_RELOAD_HIGH));
   assign w_aux_timer_control = wr & (paddr == A_AUX_TIMER_CONTROL);
   assign w_serial_control = wr & (paddr == A_SERIAL_CONTROL);
   assign w_serial_buffer = wr & (paddr == A_SERIAL_BUFFER);
   assign {rd_hit, rd_data} = rd_word(paddr, s_q);
   assign rlast = (mode == ATSP_UART8) ? M1_LAST : M9_LAST;
   assign nin = (mode == ATSP_UART8) ? rxd_in : s_q.r_sh[8]; // RULE_20
   assign rfin = (mode == ATSP_UART8) ? s_q.r_sh[8:1] : s_q.r_sh[7:0];

   // --------------------------------------------------------------
   // next state
   // --------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      // apb: latch read data at setup, answer in access
      s_d.rv = psel & ~(penable & s_q.rv);
      if (psel & ~penable) begin
         s_d.rdat = rd_data;
      end
      s_d.div = s_q.div + 2'h1;

      // counter: overflow reloads or rolls, else count up
      if (ovf) begin
         s_d.cnt = (cap & ~baud) ? RST_CNT : s_q.rld; // RULE_01 RULE_08
      end else if (tick_t) begin
         s_d.cnt = s_q.cnt + 16'h0001;
      end
      // trigger: capture or reload, none in baud mode
      if (trig & ~baud) begin
         if (cap) begin
            s_d.rld = s_q.cnt; // RULE_02
         end else begin
            s_d.cnt = s_q.rld; // RULE_08
         end
      end

      // software writes
      if (wr) begin
         unique case (paddr)
            A_POWER_CONTROL: s_d.power_control = wb & POWER_CONTROL_WMASK;
            A_SERIAL_CONTROL: s_d.serial_control = wb; // RULE_12
            A_IE: s_d.ie = wb;
            A_IP: s_d.ip = wb;
            A_AUX_TIMER_CONTROL: s_d.aux_timer_control = wb; // RULE_12
            A_AUX_RELOAD_LOW: s_d.rld[7:0] = wb;
            A_AUX_RELOAD_HIGH: s_d.rld[15:8] = wb;
            A_CNTL: s_d.cnt[7:0] = wb;
            A_CNTH: s_d.cnt[15:8] = wb;
            default: s_d.rv = 1'b0;
         endcase
      end

      // hardware flag sets come last so they beat a clear
      if (ovf & ~baud) begin
         s_d.aux_timer_control[B_TF2] = 1'b1; // RULE_10
      end
      if (trig) begin
         s_d.aux_timer_control[B_AUX_TRIGGER_FLAG] = 1'b1; // RULE_09
      end

      // transmit engine, also mode 0 receive
      if (~s_q.t_busy) begin
         s_d.t_sub = 4'h0;
         s_d.t_pre = 4'h0;
         if (w_serial_buffer) begin
            s_d.t_busy = 1'b1; // RULE_14
            s_d.t_rx = 1'b0;
            unique case (mode)
               ATSP_SHIFT: begin
                  s_d.t_sh = {3'b111, wb};
                  s_d.t_bits = M0_BITS;
               end
               ATSP_UART8: begin
                  s_d.t_sh = {2'b11, wb, 1'b0}; // RULE_23
                  s_d.t_bits = M1_BITS;
               end
               ATSP_UART9F, ATSP_UART9V: begin
                  s_d.t_sh = {1'b1, s_q.serial_control[B_TB8], wb, 1'b0}; // RULE_24 RULE_20
                  s_d.t_bits = M9_BITS;
               end
            endcase
         end else if (mode == ATSP_SHIFT && s_q.serial_control[B_REN] && !s_q.serial_control[B_RI]) begin
            s_d.t_busy = 1'b1; // RULE_19
            s_d.t_rx = 1'b1;
            s_d.t_sh = '1;
            s_d.t_bits = M0_BITS;
         end
      end else if (mode == ATSP_SHIFT) begin
         // twelve cycles per bit, sample and shift at the end
         s_d.t_pre = (s_q.t_pre == M0_LAST) ? 4'h0 : s_q.t_pre + 4'h1; // RULE_22
         if (s_q.t_pre == M0_LAST) begin
            s_d.t_sh = {s_q.t_sh[10:8], rxd_in, s_q.t_sh[7:1]};
            s_d.t_bits = s_q.t_bits - 4'h1;
            if (s_q.t_bits == 4'h1) begin
               s_d.t_busy = 1'b0;
               if (s_q.t_rx) begin
                  s_d.rbuf = {rxd_in, s_q.t_sh[7:1]};
                  s_d.serial_control[B_RI] = 1'b1; // RULE_25
               end else begin
                  s_d.serial_control[B_TI] = 1'b1; // RULE_25
               end
            end
         end
      end else if (ttick) begin
         // sixteen ticks per bit
         s_d.t_sub = s_q.t_sub + 4'h1;
         if (s_q.t_sub == OVS_LAST) begin
            s_d.t_sh = {1'b1, s_q.t_sh[10:1]};
            s_d.t_bits = s_q.t_bits - 4'h1;
            if (s_q.t_bits == 4'h1) begin
               s_d.t_busy = 1'b0;
               s_d.serial_control[B_TI] = 1'b1; // RULE_25
            end
         end
      end

      // async receive engine, runs beside transmit
      if (!s_q.serial_control[B_REN] || mode == ATSP_SHIFT) begin
         s_d.r_on = 1'b0; // RULE_19
      end else if (rtick) begin
         if (!s_q.r_on) begin
            if (!rxd_in) begin
               s_d.r_on = 1'b1;
               s_d.r_sub = 4'h0;
               s_d.r_bits = 4'h0;
            end
         end else begin
            s_d.r_sub = s_q.r_sub + 4'h1;
            if (s_q.r_sub == OVS_MID) begin
               s_d.r_bits = s_q.r_bits + 4'h1;
               if (s_q.r_bits == 4'h0) begin
                  // false start: line back high mid bit
                  s_d.r_on = ~rxd_in;
               end else if (s_q.r_bits == rlast) begin
                  s_d.r_on = 1'b0;
                  // shifter frees at once, buffer keeps last byte
                  if (!s_q.serial_control[B_RI] && (!s_q.serial_control[B_SM2] || nin)) begin
                     s_d.rbuf = rfin; // RULE_13 RULE_15
                     s_d.serial_control[B_RB8] = nin; // RULE_20
                     s_d.serial_control[B_RI] = 1'b1; // RULE_25
                  end
               end else begin
                  s_d.r_sh = {rxd_in, s_q.r_sh[8:1]};
               end
            end
         end
      end
   end

   // --------------------------------------------------------------
   // registers
   // --------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s_q <= '0; // RULE_27
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   // --------------------------------------------------------------
   // outputs
   // --------------------------------------------------------------
   assign prdata = {24'h000000, s_q.rdat};
   assign pready = s_q.rv & clk_en;
   assign pslverr = psel & penable & s_q.rv & ~rd_hit;
   // mode 0: clock low for six cycles then high
   assign txd_out = !s_q.t_busy ? 1'b1 :
                    (mode == ATSP_SHIFT) ? (s_q.t_pre >= M0_HALF) : s_q.t_sh[0]; // RULE_22
   assign rxd_out = s_q.t_sh[0];
   assign rxd_oe = s_q.t_busy & ~s_q.t_rx & (mode == ATSP_SHIFT);
   // flag requests gated by enables
   assign aux_irq_req = s_q.ie[B_EA] & s_q.ie[B_ET2] &
                        (s_q.aux_timer_control[B_TF2] | s_q.aux_timer_control[B_AUX_TRIGGER_FLAG]); // RULE_11
   assign aux_irq_high = s_q.ip[B_PT2];
   assign aux_irq_vector = AUX_IRQ_VECTOR;
   assign uart_irq_req = s_q.ie[B_EA] & s_q.ie[B_ES] & (s_q.serial_control[B_TI] | s_q.serial_control[B_RI]);

   // --------------------------------------------------------------
   // assertions
   // --------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   sequence tx1_start_s;
      w_serial_buffer && clk_en && !s_q.t_busy && mode == ATSP_UART8;
   endsequence

   sequence tx1_startbit_s;
      s_q.t_busy && !txd_out && s_q.t_bits == M1_BITS;
   endsequence

   reload_on_ovf_a: assert property ( // RULE_01
      ovf && !cap && !baud && clk_en && !w_cnt |=> s_q.cnt == $past(s_q.rld))
      else $error("count not reloaded on overflow");

   capture_on_trig_a: assert property ( // RULE_02
      trig && cap && !baud && clk_en && !w_rld |=> s_q.rld == $past(s_q.cnt))
      else $error("count not captured on trigger");

   stopped_hold_a: assert property ( // RULE_05
      !run && !trig && clk_en && !w_cnt |=> $stable(s_q.cnt))
      else $error("stopped counter moved");

   trig_flag_a: assert property ( // RULE_09
      trig && clk_en |=> s_q.aux_timer_control[B_AUX_TRIGGER_FLAG])
      else $error("trigger flag not set");

   baud_no_tf2_a: assert property ( // RULE_10
      baud && !s_q.aux_timer_control[B_TF2] && clk_en && !w_aux_timer_control |=> !s_q.aux_timer_control[B_TF2])
      else $error("overflow flag set in baud mode");

   irq_gate_a: assert property ( // RULE_11
      aux_irq_req == (s_q.ie[B_EA] && s_q.ie[B_ET2] &&
                      (s_q.aux_timer_control[B_TF2] || s_q.aux_timer_control[B_AUX_TRIGGER_FLAG])))
      else $error("aux request not gated by enables");

   rx_disabled_a: assert property ( // RULE_19
      !s_q.serial_control[B_REN] && clk_en |=> !s_q.r_on)
      else $error("receiver active while disabled");

   tx1_frame_a: assert property ( // RULE_23
      tx1_start_s |=> tx1_startbit_s)
      else $error("mode 1 frame did not start");

   ti_sticky_a: assert property ( // RULE_25
      s_q.serial_control[B_TI] && !w_serial_control |=> s_q.serial_control[B_TI])
      else $error("transmit done cleared by hardware");

   mode0_clk_a: assert property ( // RULE_22
      s_q.t_busy && mode == ATSP_SHIFT && s_q.t_pre < M0_HALF |-> !txd_out)
      else $error("mode 0 shift clock not low");
endmodule

// ### atsp_peer.sv
// Purpose: remote serial peer on the receive and transmit lines
// Assumes: nine bit frames, bit time in core clock cycles
// Notes: idle line is high, like the pull-up on the pin
module atsp_peer (
   // clock
   input wire logic core_clk,
   // serial lines
   input wire logic txd_out,
   output logic rxd_line
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------
   // state
   // ---------------------------------------------------------
   logic [8:0] got_q; // last frame seen, ninth bit on top
   int bit_cyc = 32; // cycles per bit
   initial rxd_line = 1'b1;
   // send start, eight bits lsb first, ninth bit, stop
   task automatic send(input logic [7:0] d, input logic b9);
      logic [10:0] f;
      f = {1'b1, b9, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         rxd_line <= f[i];
         repeat (bit_cyc) @(posedge core_clk);
      end
   endtask
   // capture frames from the transmit line at mid-bit
   always begin
      @(negedge txd_out);
      repeat (bit_cyc / 2) @(posedge core_clk);
      for (int i = 0; i < 9; i++) begin
         repeat (bit_cyc) @(posedge core_clk);
         got_q[i] = txd_out;
      end
      repeat (bit_cyc) @(posedge core_clk);
   end
endmodule

// ### atsp_top_tb_top.sv
// Purpose: self-checking bench for the aux timer and serial port
// Assumes: zero wait apb, mode 2 serial at clock/32
// Notes: timer1 overflow tied low, clock enable tied high
module atsp_top_tb_top;
   import atsp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------
   // signals
   // ---------------------------------------------------------
   typedef struct packed {logic [9:0] a; logic [7:0] w; logic [7:0] e; logic err;} atsp_row_t;
   localparam logic [9:0] a_tctl = 10'h320; // timer control
   localparam logic [9:0] a_rlo = 10'h328; // reload low
   localparam logic [9:0] a_rhi = 10'h32C; // reload high
   logic core_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [9:0] paddr = 10'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, cnt_pin = 1'b1, trg_pin = 1'b1, peer_rx, rxd_out, rxd_oe, txd_out;
   logic aux_irq_req, aux_irq_high, uart_irq_req, e;
   logic [7:0] aux_irq_vector;
   wire rxd_w = rxd_oe ? rxd_out : peer_rx; // shared rxd pin
   int error_cnt = 0, num_checks = 0, cyc = 0;
   atsp_row_t rows [7] = '{
      '{A_POWER_CONTROL, 8'hF8, 8'hD0, 1'b0},
      '{A_IE, 8'hB0, 8'hB0, 1'b0},
      '{A_IP, 8'h20, 8'h20, 1'b0},
      '{a_rlo, 8'h00, 8'h00, 1'b0},
      '{a_rhi, 8'h55, 8'h55, 1'b0},
      '{A_CNTL, 8'h12, 8'h12, 1'b0},
      '{10'h000, 8'hFF, 8'h00, 1'b1}};
   always #2.5 core_clk = ~core_clk;
   // ---------------------------------------------------------
   // instances
   // ---------------------------------------------------------
   atsp_top u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .aux_count_pin(cnt_pin), .aux_trigger_pin(trg_pin),
      .timer1_ovf(1'b0), .rxd_in(rxd_w), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
      .txd_out(txd_out), .aux_irq_req(aux_irq_req), .aux_irq_high(aux_irq_high),
      .aux_irq_vector(aux_irq_vector), .uart_irq_req(uart_irq_req));
   atsp_peer u_peer (.core_clk(core_clk), .txd_out(txd_out), .rxd_line(peer_rx));
   // ---------------------------------------------------------
   // tasks
   // ---------------------------------------------------------
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      num_checks++;
      if (g !== x) begin
         error_cnt++;
         $display("MISMATCH %s exp %0h got %0h", nm, x, g);
      end
   endtask
   // one apb transfer: setup, then access held until pready is sampled high
   task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n == 50) error_cnt++;
      // answer taken at the edge where pready was seen high
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle edge so outputs settle and psel is not reassigned at once
      @(posedge core_clk);
   endtask
   task automatic rdc(input logic [9:0] a, input logic [7:0] x, input string nm);
      apb(1'b0, a, 8'h00);
      chk(nm, {24'h0, x}, r);
   endtask
   // falling edges on a timer pin
   task automatic fall(input logic trg, input int k);
      repeat (k) begin
         if (trg) trg_pin <= 1'b0;
         else cnt_pin <= 1'b0;
         repeat (4) @(posedge core_clk);
         trg_pin <= 1'b1;
         cnt_pin <= 1'b1;
         repeat (4) @(posedge core_clk);
      end
   endtask
   // hang guard
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         summarize();
      end
   end
   // ---------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------
   initial begin
      repeat (6) @(posedge core_clk);
      sys_rst <= 1'b0;
      foreach (rows[i]) begin
         rdc(rows[i].a, 8'h00, "reset");
         apb(1'b1, rows[i].a, rows[i].w);
         rdc(rows[i].a, rows[i].e, "readback");
         chk("slverr", {31'h0, rows[i].err}, {31'h0, e});
      end
      chk("vector", 32'h2B, {24'h0, aux_irq_vector});
      chk("prio", 32'h1, {31'h0, aux_irq_high});
      // auto-reload from near overflow, then stop with flag kept
      apb(1'b1, A_CNTH, 8'hFF);
      apb(1'b1, A_CNTL, 8'hFE);
      apb(1'b1, a_tctl, 8'h04);
      repeat (20) @(posedge core_clk);
      apb(1'b1, a_tctl, 8'h80);
      rdc(A_CNTH, 8'h55, "reloaded");
      rdc(a_tctl, 8'h80, "ovf flag");
      chk("irq set", 32'h1, {31'h0, aux_irq_req});
      apb(1'b1, a_tctl, 8'h00);
      chk("irq clr", 32'h0, {31'h0, aux_irq_req});
      // external events counted only while running
      apb(1'b1, A_CNTL, 8'h00);
      apb(1'b1, A_CNTH, 8'h00);
      apb(1'b1, a_tctl, 8'h06);
      fall(1'b0, 3);
      apb(1'b1, a_tctl, 8'h02);
      fall(1'b0, 2);
      rdc(A_CNTL, 8'h03, "events");
      // trigger ignored, then capture
      apb(1'b1, a_tctl, 8'h01);
      fall(1'b1, 1);
      rdc(a_tctl, 8'h01, "no trig");
      apb(1'b1, a_tctl, 8'h09);
      fall(1'b1, 1);
      rdc(a_tctl, 8'h49, "trig flag");
      rdc(a_rlo, 8'h03, "capture");
      chk("irq trig", 32'h1, {31'h0, aux_irq_req});
      // mode 2 duplex: send and receive at once
      apb(1'b1, A_SERIAL_CONTROL, 8'h98);
      fork
         u_peer.send(8'h3C, 1'b1);
         apb(1'b1, A_SERIAL_BUFFER, 8'h5A);
      join
      repeat (60) @(posedge core_clk);
      chk("tx frame", 32'h15A, {23'h0, u_peer.got_q});
      rdc(A_SERIAL_BUFFER, 8'h3C, "rx byte");
      rdc(A_SERIAL_CONTROL, 8'h9F, "done bits");
      chk("uart irq", 32'h1, {31'h0, uart_irq_req});
      // filter drops data frame, passes address frame
      apb(1'b1, A_SERIAL_CONTROL, 8'hB0);
      u_peer.send(8'h77, 1'b0);
      rdc(A_SERIAL_CONTROL, 8'hB0, "filtered");
      u_peer.send(8'h66, 1'b1);
      rdc(A_SERIAL_CONTROL, 8'hB5, "address");
      // receiver disabled
      apb(1'b1, A_SERIAL_CONTROL, 8'h80);
      u_peer.send(8'h11, 1'b1);
      rdc(A_SERIAL_CONTROL, 8'h80, "rx off");
      rdc(A_SERIAL_BUFFER, 8'h66, "kept");
      summarize();
   end
endmodule
